// file: fdc_cfg.svh
`ifndef FDC_CFG_SVH
`define FDC_CFG_SVH
// ------------------------------------------------------------
// device register offsets on the link (3-bit address)
// ------------------------------------------------------------
`define FDC_OFS_DRVOUT     3'h0
`define FDC_OFS_DSR        3'h1
`define FDC_OFS_MSR        3'h2
`define FDC_OFS_DATA       3'h3
`define FDC_OFS_MODE       3'h4
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FDC_DRVOUT_RST_BIT 2
`define FDC_DSR_RST_BIT    7
`define FDC_DSR_PDN_BIT    6
`define FDC_MODE_LSB       2
`define FDC_MODE_MSB       3
`define FDC_CFG_POLL_BIT   4
// ------------------------------------------------------------
// reset values and the invalid-command status byte
// ------------------------------------------------------------
`define FDC_RATE_RESET     2'h2
`define FDC_ST0_INVALID    8'h80
// ------------------------------------------------------------
// command codes (low five bits), byte counts and execute cycle count
// ------------------------------------------------------------
`define FDC_CMD_VERIFY     5'h16
`define FDC_CMD_FORMAT     5'h0D
`define FDC_CMD_SPECIFY    5'h03
`define FDC_CMD_CONFIGURE  5'h13
`define FDC_LEN_VERIFY     11'h009
`define FDC_LEN_FORMAT     11'h006
`define FDC_LEN_SPECIFY    11'h003
`define FDC_LEN_CONFIGURE  11'h004
`define FDC_RES_LEN        3'h7
`define FDC_EXEC_CYCLES    8'h10
// ------------------------------------------------------------
// host-side apb offsets
// ------------------------------------------------------------
`define FDC_APB_CTRL       12'h000
`define FDC_APB_ACCESS     12'h004
`define FDC_APB_STATUS     12'h008
`endif

// file: fdc_disk_controller.sv
`default_nettype none
`include "fdc_cfg.svh"
// Contract
// - reset from pin, two soft bits, power-on
// - pin and soft resets leave power down; power-on does not
// - pin reset aborts work, goes idle
// - leaving reset clears registers and configuration
// - polling starts unless configuration disables it
// - pin reset keeps timing setup values
// - pin reset sets drive output reset bit
// - both soft bits reset the core alike
// - rate reset self-clears, drive reset sticks
// - drive output reset takes precedence
// - mode bits 3:2 select interface mode
// - verify: nine bytes in, seven out
// - format: header then four bytes per sector
// - rate kept by soft reset, 250k on pin
module fdc_disk_controller (
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   power_on_n,
   fdc_link_if.device  link,
   output var  logic [1:0] interface_mode,
   output var  logic [1:0] data_rate,
   output var  logic   drive_poll,
   output var  logic   write_gate,
   output var  logic   head_select,
   output var  logic   drive_select_hi,
   output var  logic   drive_select_lo,
   output var  logic   powered_down,
   output var  logic   core_in_reset,
   output var  logic [7:0] step_rate_head_unload,
   output var  logic [7:0] head_load_time
);
   // ------------------------------------------------------------
   // reset
   // ------------------------------------------------------------
   logic hw_rst_n;
   logic drvout_rst;
   logic dsr_rst;
   logic core_rst;

   fdc_rst_sync u_pin_sync (
      .pclk   (pclk),
      .arst_n (presetn & link.host_bus_reset_pin_n),
      .rst_n  (hw_rst_n)
   );

   // drive output bit is the stronger source and keeps the core held on its own
   assign core_rst = drvout_rst | dsr_rst;

   // ------------------------------------------------------------
   // link decode
   // ------------------------------------------------------------
   logic wr_drvout;
   logic wr_dsr;
   logic wr_data;
   logic wr_mode;
   logic rd_data;
   assign wr_drvout = link.reg_wr && link.reg_addr == `FDC_OFS_DRVOUT;
   assign wr_dsr  = link.reg_wr && link.reg_addr == `FDC_OFS_DSR;
   assign wr_data = link.reg_wr && link.reg_addr == `FDC_OFS_DATA;
   assign wr_mode = link.reg_wr && link.reg_addr == `FDC_OFS_MODE;
   assign rd_data = link.reg_rd && link.reg_addr == `FDC_OFS_DATA;

   // ------------------------------------------------------------
   // drive output register
   // ------------------------------------------------------------
   logic [1:0] drvout_drive;
   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         drvout_rst   <= 1'b1;
         drvout_drive <= 2'h0;
      end else if (wr_drvout) begin
         drvout_rst   <= link.reg_wdata[`FDC_DRVOUT_RST_BIT];
         drvout_drive <= link.reg_wdata[1:0];
      end
   end

   // ------------------------------------------------------------
   // data rate select register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         data_rate <= `FDC_RATE_RESET;
         dsr_rst   <= 1'b0;
      end else if (wr_dsr) begin
         data_rate <= link.reg_wdata[1:0];
         dsr_rst   <= link.reg_wdata[`FDC_DSR_RST_BIT];
      end else begin
         dsr_rst   <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         powered_down <= 1'b0;
      end else if (core_rst) begin
         powered_down <= 1'b0;
      end else if (wr_dsr) begin
         powered_down <= link.reg_wdata[`FDC_DSR_PDN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         interface_mode <= 2'h0;
      end else if (wr_mode) begin
         interface_mode <= link.reg_wdata[`FDC_MODE_MSB:`FDC_MODE_LSB];
      end
   end

   // ------------------------------------------------------------
   // command engine
   // ------------------------------------------------------------
   fdc_pkg::fdc_state_t state;
   fdc_pkg::fdc_byte_t  pbuf [0:9];
   fdc_pkg::fdc_byte_t  rbuf [0:6];
   logic [10:0] idx;
   logic [10:0] need;
   logic [2:0]  ridx;
   logic [2:0]  rlen;
   logic [7:0]  exec_cnt;
   logic        poll_disable;
   logic [4:0]  op;
   logic [10:0] next_need;
   logic [3:0]  slot;

   assign op = pbuf[0][4:0];

   // byte count depends on opcode, and for format on the sector count
   always_comb begin
      next_need = 11'h001;
      case (op)
         `FDC_CMD_VERIFY:    next_need = `FDC_LEN_VERIFY;
         `FDC_CMD_FORMAT:    next_need = `FDC_LEN_FORMAT + {1'b0, pbuf[3], 2'b00};
         `FDC_CMD_SPECIFY:   next_need = `FDC_LEN_SPECIFY;
         `FDC_CMD_CONFIGURE: next_need = `FDC_LEN_CONFIGURE;
         default:            next_need = 11'h001;
      endcase
   end

   // format sector bytes rotate through the last four slots
   assign slot = (idx < 11'd6) ? idx[3:0] : (4'd6 + {2'b00, idx[1:0] - 2'd2});

   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         state <= fdc_pkg::FDC_IDLE;
         idx   <= 11'h000;
         need  <= 11'h001;
      end else if (core_rst) begin
         state <= fdc_pkg::FDC_IDLE;
         idx   <= 11'h000;
         need  <= 11'h001;
      end else begin
         case (state)
            fdc_pkg::FDC_IDLE: begin
               if (wr_data && !powered_down) begin
                  idx   <= 11'h001;
                  state <= fdc_pkg::FDC_COMMAND;
               end
            end
            fdc_pkg::FDC_COMMAND: begin
               need <= next_need;
               if (idx >= next_need && idx != 11'h000) begin
                  state <= fdc_pkg::FDC_EXECUTE;
               end else if (wr_data) begin
                  idx <= idx + 11'h001;
               end
            end
            fdc_pkg::FDC_EXECUTE: begin
               if (exec_cnt == 8'h00) begin
                  state <= (rlen == 3'h0) ? fdc_pkg::FDC_IDLE : fdc_pkg::FDC_RESULT;
               end
            end
            fdc_pkg::FDC_RESULT: begin
               if (rd_data && ridx + 3'h1 >= rlen) begin
                  state <= fdc_pkg::FDC_IDLE;
               end
            end
            default: state <= fdc_pkg::FDC_IDLE;
         endcase
      end
   end

   generate
      for (genvar i = 0; i < 10; i++) begin : g_pbuf
         always_ff @(posedge pclk or negedge hw_rst_n) begin
            if (!hw_rst_n) begin
               pbuf[i] <= 8'h00;
            end else if (core_rst) begin
               pbuf[i] <= 8'h00;
            end else if (wr_data && state == fdc_pkg::FDC_IDLE && i == 0) begin
               pbuf[i] <= link.reg_wdata;
            end else if (wr_data && state == fdc_pkg::FDC_COMMAND && slot == i) begin
               pbuf[i] <= link.reg_wdata;
            end
         end
      end
   endgenerate

   // execution: verify moves no data, format holds write gate
   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         exec_cnt   <= `FDC_EXEC_CYCLES;
         write_gate <= 1'b0;
      end else if (core_rst || state != fdc_pkg::FDC_EXECUTE) begin
         exec_cnt   <= `FDC_EXEC_CYCLES;
         write_gate <= 1'b0;
      end else begin
         exec_cnt   <= exec_cnt - 8'h01;
         write_gate <= (op == `FDC_CMD_FORMAT) && exec_cnt != 8'h00;
      end
   end

   // results are built as the command phase ends, before execution
   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         rlen <= 3'h0;
         ridx <= 3'h0;
         for (int k = 0; k < 7; k++) rbuf[k] <= 8'h00;
      end else if (core_rst) begin
         rlen <= 3'h0;
         ridx <= 3'h0;
      end else if (state == fdc_pkg::FDC_COMMAND && idx >= next_need && idx != 11'h000) begin
         ridx    <= 3'h0;
         rbuf[0] <= {5'h00, pbuf[1][2:0]};
         rbuf[1] <= 8'h00;
         rbuf[2] <= 8'h00;
         case (op)
            `FDC_CMD_VERIFY: begin
               rlen <= `FDC_RES_LEN;
               for (int k = 0; k < 4; k++) rbuf[3 + k] <= pbuf[2 + k];
            end
            `FDC_CMD_FORMAT: begin
               rlen <= `FDC_RES_LEN;
               for (int k = 0; k < 4; k++) rbuf[3 + k] <= pbuf[6 + k];
            end
            `FDC_CMD_SPECIFY, `FDC_CMD_CONFIGURE: rlen <= 3'h0;
            default: begin
               rlen    <= 3'h1;
               rbuf[0] <= `FDC_ST0_INVALID;
            end
         endcase
      end else if (rd_data && state == fdc_pkg::FDC_RESULT) begin
         ridx <= ridx + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // configuration and timing setup
   // ------------------------------------------------------------
   logic cmd_done;
   assign cmd_done = state == fdc_pkg::FDC_EXECUTE && exec_cnt == 8'h00;

   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         poll_disable <= 1'b0;
      end else if (core_rst) begin
         poll_disable <= 1'b0;
      end else if (cmd_done && op == `FDC_CMD_CONFIGURE) begin
         poll_disable <= pbuf[2][`FDC_CFG_POLL_BIT];
      end
   end

   // only power-on clears these; the pin reset leaves them alone
   always_ff @(posedge pclk or negedge power_on_n) begin
      if (!power_on_n) begin
         step_rate_head_unload <= 8'h00;
         head_load_time        <= 8'h00;
      end else if (cmd_done && op == `FDC_CMD_SPECIFY) begin
         step_rate_head_unload <= pbuf[1];
         head_load_time        <= pbuf[2];
      end
   end

   // ------------------------------------------------------------
   // outputs and read data
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         drive_poll      <= 1'b0;
         core_in_reset   <= 1'b1;
         head_select     <= 1'b0;
         drive_select_hi <= 1'b0;
         drive_select_lo <= 1'b0;
      end else begin
         drive_poll      <= !core_rst && !poll_disable && !powered_down && state == fdc_pkg::FDC_IDLE;
         core_in_reset   <= core_rst;
         head_select     <= pbuf[1][2];
         drive_select_hi <= drvout_drive[1];
         drive_select_lo <= drvout_drive[0];
      end
   end

   always_ff @(posedge pclk or negedge hw_rst_n) begin
      if (!hw_rst_n) begin
         link.reg_rdata <= 8'h00;
      end else if (link.reg_rd) begin
         case (link.reg_addr)
            `FDC_OFS_DRVOUT: link.reg_rdata <= {5'h00, drvout_rst, drvout_drive};
            `FDC_OFS_DSR:  link.reg_rdata <= {1'b0, powered_down, 4'h0, data_rate};
            // request bit is up whenever the host may move a byte, result bytes included
            `FDC_OFS_MSR:  link.reg_rdata <= {state != fdc_pkg::FDC_EXECUTE,
                                              state == fdc_pkg::FDC_RESULT, state != fdc_pkg::FDC_IDLE,
                                              drvout_rst, dsr_rst, poll_disable, interface_mode};
            `FDC_OFS_DATA: link.reg_rdata <= (state == fdc_pkg::FDC_RESULT) ? rbuf[ridx] : 8'h00;
            `FDC_OFS_MODE: link.reg_rdata <= {4'h0, interface_mode, 2'h0};
            default:       link.reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule : fdc_disk_controller
`default_nettype wire

// file: fdc_host_ctrl.sv
`default_nettype none
`include "fdc_cfg.svh"
module fdc_host_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   fdc_link_if.host         link
);
   // ------------------------------------------------------------
   // apb slave: answers in the first access cycle
   // ------------------------------------------------------------
   logic       setup;
   logic       rd_pending;
   logic       busy;
   logic [7:0] last_rdata;
   assign setup = psel && !penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup && paddr != `FDC_APB_CTRL && paddr != `FDC_APB_ACCESS && paddr != `FDC_APB_STATUS;
         if (setup && !pwrite) begin
            case (paddr)
               `FDC_APB_CTRL:   prdata <= {31'h00000000, !link.host_bus_reset_pin_n};
               `FDC_APB_STATUS: prdata <= {16'h0000, last_rdata, 7'h00, busy};
               default:         prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // link side: one-cycle strobes, read data one cycle later
   // ------------------------------------------------------------
   logic wr_ctrl;
   logic wr_access;
   assign wr_ctrl   = psel && penable && pready && pwrite && paddr == `FDC_APB_CTRL;
   assign wr_access = psel && penable && pready && pwrite && paddr == `FDC_APB_ACCESS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.host_bus_reset_pin_n <= 1'b0;
      end else if (wr_ctrl) begin
         link.host_bus_reset_pin_n <= !pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.reg_addr  <= 3'h0;
         link.reg_wdata <= 8'h00;
         link.reg_wr    <= 1'b0;
         link.reg_rd    <= 1'b0;
      end else begin
         link.reg_wr <= wr_access && !pwdata[11];
         link.reg_rd <= wr_access && pwdata[11];
         if (wr_access) begin
            link.reg_addr  <= pwdata[10:8];
            link.reg_wdata <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pending <= 1'b0;
         busy       <= 1'b0;
         last_rdata <= 8'h00;
      end else begin
         rd_pending <= link.reg_rd;
         busy       <= wr_access || link.reg_rd || link.reg_wr;
         if (rd_pending) begin
            last_rdata <= link.reg_rdata;
         end
      end
   end
endmodule : fdc_host_ctrl
`default_nettype wire

// file: fdc_link_checker.sv
`default_nettype none
module fdc_link_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       host_bus_reset_pin_n,
   input wire logic [2:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] interface_mode,
   input wire logic [1:0] data_rate,
   input wire logic       drive_poll,
   input wire logic       write_gate,
   input wire logic       powered_down,
   input wire logic       core_in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pin_hist;
   logic       pin_ok;
   logic       drvout_set;
   // --------------------------------------------
   // helper state
   // --------------------------------------------
   // pin_ok covers the two-edge release sync, so soft checks skip it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pin_hist <= 3'h0;
      else pin_hist <= {pin_hist[1:0], host_bus_reset_pin_n};
   end
   assign pin_ok = (&pin_hist) & host_bus_reset_pin_n;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) drvout_set <= 1'h1;
      else if (!host_bus_reset_pin_n) drvout_set <= 1'h1;
      else if (reg_wr && reg_addr == 3'h0) drvout_set <= reg_wdata[2];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // --------------------------------------------
   // properties
   // --------------------------------------------
   property p_pin_rate;
      !host_bus_reset_pin_n |-> data_rate == 2'h2 && core_in_reset;
   endproperty
   a_pin_rate: assert property (p_pin_rate) else $error("rate or core reset wrong in pin reset");
   property p_pin_idle;
      !host_bus_reset_pin_n |-> !write_gate && !drive_poll && !powered_down;
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("activity during pin reset");
   property p_dor_hold;
      drvout_set && $past(drvout_set) |-> core_in_reset;
   endproperty
   a_dor_hold: assert property (p_dor_hold) else $error("core left reset with drive reset set");
   property p_dsr_pulse;
      reg_wr && reg_addr == 3'h1 && reg_wdata[7] && pin_ok && !drvout_set
         |-> ##[1:2] core_in_reset ##[1:3] !core_in_reset;
   endproperty
   a_dsr_pulse: assert property (p_dsr_pulse) else $error("rate reset did not pulse");
   property p_mode;
      reg_wr && reg_addr == 3'h4 && pin_ok |=> ##1 interface_mode == $past(reg_wdata[3:2], 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bits not applied");
   property p_rate_keep;
      reg_wr && reg_addr == 3'h0 && pin_ok |=> $stable(data_rate) [*3];
   endproperty
   a_rate_keep: assert property (p_rate_keep) else $error("rate moved on soft reset");
   property p_poll_off;
      core_in_reset && $past(core_in_reset) |-> !drive_poll;
   endproperty
   a_poll_off: assert property (p_poll_off) else $error("polling during core reset");
   property p_rdata_hold;
      pin_ok && !$past(reg_rd) |-> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
   c_pin: cover property ($rose(host_bus_reset_pin_n));
   c_gate: cover property ($rose(write_gate));
   c_dsr: cover property (reg_wr && reg_addr == 3'h1 && reg_wdata[7]);
endmodule : fdc_link_checker
`default_nettype wire

// file: fdc_link_if.sv
`default_nettype none
interface fdc_link_if;
   logic             host_bus_reset_pin_n;
   logic [2:0]       reg_addr;
   logic             reg_wr;
   logic             reg_rd;
   fdc_pkg::fdc_byte_t reg_wdata;
   fdc_pkg::fdc_byte_t reg_rdata;
   modport device (input host_bus_reset_pin_n, reg_addr, reg_wr, reg_rd, reg_wdata, output reg_rdata);
   modport host   (output host_bus_reset_pin_n, reg_addr, reg_wr, reg_rd, reg_wdata, input reg_rdata);
endinterface : fdc_link_if
`default_nettype wire

// file: fdc_pkg.sv
`default_nettype none
package fdc_pkg;
   typedef enum logic [1:0] {FDC_IDLE, FDC_COMMAND, FDC_EXECUTE, FDC_RESULT} fdc_state_t;
   typedef logic [7:0] fdc_byte_t;
endpackage : fdc_pkg
`default_nettype wire

// file: fdc_rst_sync.sv
`default_nettype none
module fdc_rst_sync (
   input  wire logic pclk,
   input  wire logic arst_n,
   output var  logic rst_n
);
   logic meta;
   // assertion is immediate, release waits two edges
   always_ff @(posedge pclk or negedge arst_n) begin
      if (!arst_n) begin
         meta  <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         meta  <= 1'b1;
         rst_n <= meta;
      end
   end
endmodule : fdc_rst_sync
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, power_on_n, psel, penable, pwrite, pready, pslverr, serr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  interface_mode, data_rate;
   logic        drive_poll, write_gate, head_select, drive_select_hi, drive_select_lo;
   logic        powered_down, core_in_reset;
   logic [7:0]  step_rate_head_unload, head_load_time;
   logic [7:0]  q[$];
   int          num_errors, total_checks;
   fdc_link_if link_i ();
   fdc_host_ctrl fdc_host_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .link(link_i.host));
   fdc_disk_controller fdc_disk_controller_i (.pclk, .presetn, .power_on_n, .link(link_i.device),
      .interface_mode, .data_rate, .drive_poll, .write_gate, .head_select, .drive_select_hi,
      .drive_select_lo, .powered_down, .core_in_reset, .step_rate_head_unload, .head_load_time);
   fdc_link_checker fdc_link_checker_i (.pclk, .presetn,
      .host_bus_reset_pin_n(link_i.host_bus_reset_pin_n), .reg_addr(link_i.reg_addr),
      .reg_wr(link_i.reg_wr), .reg_rd(link_i.reg_rd), .reg_wdata(link_i.reg_wdata),
      .reg_rdata(link_i.reg_rdata), .interface_mode, .data_rate, .drive_poll, .write_gate,
      .powered_down, .core_in_reset);
   // --------------------------------------------
   // bus tasks
   // --------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         $display("BAD %0t no pready", $time);
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // the link walk settles three cycles after the access write
   task automatic dw(input logic [2:0] a, input logic [7:0] d);
      apb(1'h1, 12'h004, {20'h0, 1'h0, a, d});
      repeat (4) @(posedge pclk);
   endtask : dw
   task automatic dr(input logic [2:0] a);
      apb(1'h1, 12'h004, {20'h0, 1'h1, a, 8'h00});
      repeat (4) @(posedge pclk);
      apb(1'h0, 12'h008, 32'h0);
      rd = {24'h0, rd[15:8]};
   endtask : dr
   task automatic send();
      foreach (q[i]) dw(3'h3, q[i]);
   endtask : send
   task automatic wait_result();
      int n;
      n = 0;
      do begin
         dr(3'h2);
         n++;
      end while (rd[7:6] !== 2'h3 && n < 40);
      if (n >= 40) begin
         num_errors++;
         $display("BAD %0t no result phase", $time);
      end
   endtask : wait_result
   task automatic pin_pulse();
      apb(1'h1, 12'h000, 32'h1);
      apb(1'h1, 12'h000, 32'h0);
      repeat (4) @(posedge pclk);
   endtask : pin_pulse
   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   task automatic t_reset();
      apb(1'h0, 12'h000, 32'h0);
      chk(rd, 32'h1);
      chk(data_rate, 2'h2);
      apb(1'h1, 12'h000, 32'h0);
      repeat (6) @(posedge pclk);
      chk(core_in_reset, 1'h1);
      dr(3'h2);
      chk(rd[4], 1'h1);
      dw(3'h0, 8'h00);
      chk(core_in_reset, 1'h0);
      chk(drive_poll, 1'h1);
      apb(1'h0, 12'h00C, 32'h0);
      chk(serr, 1'h1);
   endtask : t_reset
   task automatic t_mode();
      int m;
      for (m = 0; m < 4; m++) begin
         dw(3'h4, {4'h0, m[1:0], 2'h0});
         chk(interface_mode, m[1:0]);
      end
   endtask : t_mode
   task automatic t_specify();
      q = '{8'h03, 8'hAB, 8'h5C};
      send();
      repeat (20) @(posedge pclk);
      chk({step_rate_head_unload, head_load_time}, 16'hAB5C);
      dw(3'h4, 8'h08);
      pin_pulse();
      chk({step_rate_head_unload, head_load_time}, 16'hAB5C);
      chk(interface_mode, 2'h0);
      chk(core_in_reset, 1'h1);
      dw(3'h0, 8'h00);
   endtask : t_specify
   task automatic t_verify();
      q = '{8'hF6, 8'h06, 8'h12, 8'h01, 8'h05, 8'h02, 8'h09, 8'h1B, 8'hFF};
      send();
      chk(write_gate, 1'h0);
      wait_result();
      q = '{8'h06, 8'h00, 8'h00, 8'h12, 8'h01, 8'h05, 8'h02};
      foreach (q[i]) begin
         dr(3'h3);
         chk(rd, q[i]);
      end
      chk({head_select, drive_select_hi, drive_select_lo}, 3'h4);
   endtask : t_verify
   task automatic t_format(input logic abort);
      q = '{8'h4D, 8'h01, 8'h02, 8'h02, 8'h54, 8'hE5, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h02, 8'h02};
      send();
      chk(write_gate, 1'h1);
      if (abort) begin
         pin_pulse();
         chk(write_gate, 1'h0);
         dw(3'h0, 8'h00);
         dr(3'h2);
         chk(rd[7:5], 3'h4);
      end else begin
         wait_result();
         q = '{8'h03, 8'h00, 8'h02, 8'h02};
         repeat (3) dr(3'h3);
         foreach (q[i]) begin
            dr(3'h3);
            chk(rd, q[i]);
         end
         chk(write_gate, 1'h0);
      end
   endtask : t_format
   task automatic t_soft();
      q = '{8'h13, 8'h00, 8'h10, 8'h00};
      send();
      repeat (20) @(posedge pclk);
      chk(drive_poll, 1'h0);
      dw(3'h1, 8'h81);
      chk({drive_poll, core_in_reset}, 2'h2);
      chk(data_rate, 2'h1);
      q = '{8'h13, 8'h00, 8'h10, 8'h00};
      send();
      dw(3'h0, 8'h04);
      dw(3'h1, 8'h82);
      repeat (6) @(posedge pclk);
      chk(core_in_reset, 1'h1);
      dw(3'h0, 8'h00);
      chk({drive_poll, core_in_reset}, 2'h2);
   endtask : t_soft
   task automatic t_powerdown();
      dw(3'h1, 8'h42);
      chk(powered_down, 1'h1);
      dw(3'h0, 8'h04);
      chk(powered_down, 1'h0);
      dw(3'h0, 8'h00);
      dw(3'h1, 8'h42);
      apb(1'h1, 12'h000, 32'h1);
      repeat (2) @(posedge pclk);
      chk(powered_down, 1'h0);
      apb(1'h1, 12'h000, 32'h0);
      repeat (4) @(posedge pclk);
      dw(3'h0, 8'h00);
   endtask : t_powerdown
   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      $display("BAD %0t timeout", $time);
      final_report();
   end
   initial begin
      presetn = 1'h0; power_on_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
      paddr = 12'h000; pwdata = 32'h0; num_errors = 0; total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      power_on_n <= 1'h1;
      t_reset();
      t_mode();
      t_specify();
      t_verify();
      t_format(1'h0);
      t_soft();
      t_powerdown();
      t_format(1'h1);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
